// ===== clcp_map.vh
/*
 * register offsets, field positions, reset values and timing counts for the
 * cpu local bus coprocessor support block.
 * assumes: included by the design files of this block by bare name.
 */
`ifndef CLCP_MAP_VH
`define CLCP_MAP_VH

// offsets are word indices: the bus byte address is the index times four
`define CLCP_ADDR_W          10
`define CLCP_OFF_FEATURE_ONE 8'ha0
`define CLCP_OFF_FEATURE_THR 8'had
`define CLCP_OFF_STATUS      8'hb0
`define CLCP_OFF_OPTION      8'hb4
`define CLCP_RST_FEATURE_ONE 8'h00
`define CLCP_RST_FEATURE_THR 8'h00
`define CLCP_RST_OPTION      8'h00

`define CLCP_F1_MASTER_EN    5
`define CLCP_F3_READY_DIRECT 0
`define CLCP_F3_DETECT_OFF   1
`define CLCP_F3_PIN80_DACK   2
`define CLCP_F3_SOFT_RESET   3
`define CLCP_F3_ADDR20_MASK_FORCE   4
`define CLCP_F3_CPU_ZERO_V   5
`define CLCP_F3_IGNORE_CLAIM 7
`define CLCP_OPT_WB_CACHE    0

`define CLCP_ST_PRESENT      0
`define CLCP_ST_BUSY_LATCH   1
`define CLCP_ST_IRQ13        2
`define CLCP_ST_STRAP_386    3
`define CLCP_ST_STRAP_RDYPIN 4

`define CLCP_FP_PORT         16'h00f0
`define CLCP_RESET_CYCLES    128
`define CLCP_PWR_DELAY       16

`define CLCP_RESP_OKAY       2'b00
`define CLCP_RESP_SLVERR     2'b10

`endif

// ===== clcp_sync3.v
/*
 * three flip-flop input synchroniser with agreement filter.
 * assumes: input is asynchronous to clk; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none
module clcp_sync3 #(
	parameter W    = 1,
	parameter INIT = 1'b1
) (
	input  wire         clk,
	input  wire         reset,
	input  wire [W-1:0] async,
	output reg  [W-1:0] clean
);
	reg [W-1:0] s1Reg;
	reg [W-1:0] s2Reg;
	reg [W-1:0] s3Reg;
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk or posedge reset) begin
				if (reset) begin
					s1Reg[i] <= INIT;
					s2Reg[i] <= INIT;
					s3Reg[i] <= INIT;
					clean[i] <= INIT;
				end else begin
					s1Reg[i] <= async[i];
					s2Reg[i] <= s1Reg[i];
					s3Reg[i] <= s2Reg[i];
					if (s2Reg[i] == s3Reg[i])
						clean[i] <= s3Reg[i];
				end
			end
		end
	endgenerate
endmodule // clcp_sync3
`default_nettype wire

// ===== clcp_axil_regs.v
/*
 * axi4-lite slave holding the two feature control registers and an option register,
 * and reading back block status.
 * assumes: one outstanding write and one outstanding read; 10-bit byte address, registers on word indices.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clcp_map.vh"
module clcp_axil_regs (
	input  wire        clk,
	input  wire        reset,
	input  wire [9:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [9:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	input  wire [7:0]  statusIn,
	output reg  [7:0]  featureOne_reg,
	output reg  [7:0]  featureThree_reg,
	output reg  [7:0]  option_reg
);
	reg [9:0] awAddr_reg;
	reg       awHave_reg;
	reg [7:0] wData_reg;
	reg       wStrb_reg;
	reg       wHave_reg;
	wire      doWrite = awHave_reg && wHave_reg && !bvalid;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			awready          <= 1'b1;
			wready           <= 1'b1;
			awHave_reg       <= 1'b0;
			wHave_reg        <= 1'b0;
			awAddr_reg       <= 10'h000;
			wData_reg        <= 8'h00;
			wStrb_reg        <= 1'b0;
			bvalid           <= 1'b0;
			bresp            <= `CLCP_RESP_OKAY;
			featureOne_reg   <= `CLCP_RST_FEATURE_ONE;
			featureThree_reg <= `CLCP_RST_FEATURE_THR;
			option_reg       <= `CLCP_RST_OPTION;
		end else begin
			if (awvalid && awready) begin
				awAddr_reg <= awaddr;
				awHave_reg <= 1'b1;
				awready    <= 1'b0;
			end
			if (wvalid && wready) begin
				wData_reg <= wdata[7:0];
				wStrb_reg <= wstrb[0];
				wHave_reg <= 1'b1;
				wready    <= 1'b0;
			end
			if (doWrite) begin
				awHave_reg <= 1'b0;
				wHave_reg  <= 1'b0;
				bvalid     <= 1'b1;
				bresp      <= `CLCP_RESP_OKAY;
				case (awAddr_reg[9:2])
					`CLCP_OFF_FEATURE_ONE: if (wStrb_reg) featureOne_reg <= wData_reg;
					`CLCP_OFF_FEATURE_THR: if (wStrb_reg) featureThree_reg <= wData_reg;
					`CLCP_OFF_OPTION: if (wStrb_reg) option_reg <= wData_reg;
					`CLCP_OFF_STATUS: bresp <= `CLCP_RESP_OKAY;
					default: bresp <= `CLCP_RESP_SLVERR;
				endcase
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `CLCP_RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rresp   <= `CLCP_RESP_OKAY;
				case (araddr[9:2])
					`CLCP_OFF_FEATURE_ONE: rdata <= {24'h000000, featureOne_reg};
					`CLCP_OFF_FEATURE_THR: rdata <= {24'h000000, featureThree_reg};
					`CLCP_OFF_OPTION: rdata <= {24'h000000, option_reg};
					`CLCP_OFF_STATUS: rdata <= {24'h000000, statusIn};
					default: begin
						rdata <= 32'h00000000;
						rresp <= `CLCP_RESP_SLVERR;
					end
				endcase
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule // clcp_axil_regs
`default_nettype wire

// ===== clcp_coproc_support.v
/*
 * cpu local bus coprocessor support: presence detection, cycle claim, ready
 * combining, busy latch with irq13, local master pin muxing, swap buffer control,
 * and cpu power-down, address-20 and soft reset options.
 * assumes: cpu cycle decode is done upstream and presented as a cycle start pulse
 * with address, type and size; isa cycle engine reports its own completion.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clcp_map.vh"
module clcp_coproc_support #(
	parameter RESET_CYCLES = `CLCP_RESET_CYCLES,
	parameter PWR_DELAY    = `CLCP_PWR_DELAY
) (
	input  wire        clk,
	input  wire        reset,
	input  wire [9:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output wire [1:0]  bresp,
	output wire        bvalid,
	input  wire        bready,
	input  wire [9:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output wire [31:0] rdata,
	output wire [1:0]  rresp,
	output wire        rvalid,
	input  wire        rready,
	input  wire        strap386,
	input  wire        strapReadyPin,
	input  wire        cycleStart,
	input  wire        cycleIsIo,
	input  wire        cycleIsWrite,
	input  wire        cycleInDram,
	input  wire [15:0] cycleIoAddr,
	input  wire        cpuAddrTopBit,
	input  wire [1:0]  cycleCpuSize,
	input  wire [1:0]  cycleDevSize,
	input  wire        isaCycleDone,
	input  wire        coprocReadyIn_n,
	input  wire        localDeviceClaim_n,
	input  wire        fpErrorIn_n,
	input  wire        fpBusyIn_n,
	input  wire        localMasterRequestIn_n,
	input  wire        progIoZeroIn,
	input  wire        dmaAckCh2Int_n,
	input  wire        fpIntInt,
	input  wire        gateAddr20Int,
	input  wire        suspendActive,
	input  wire [2:0]  encodedAckInt,
	output reg         cpuReady_n,
	output reg         cpuReadyOe,
	output reg         isaCycleReq,
	output reg  [2:0]  isaPieceCount,
	output reg         fpResetOut,
	output reg         irq13,
	output reg         localMasterGrant,
	output reg         pin80Out,
	output reg         progIoZeroOut,
	output reg         localMasterReq,
	output reg  [2:0]  encodedAckLines,
	output reg         swapBufferEnableHigh_n,
	output reg         swapBufferEnableLow_n,
	output reg         swapBufferDirection,
	output reg         addr20Pin,
	output reg         cpuHardReset,
	output reg         cpuSoftReset
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_LOCAL = 2'd1;
	localparam ST_ISA   = 2'd2;
	localparam ST_END   = 2'd3;

	wire [7:0] featureOne_reg;
	wire [7:0] featureThree_reg;
	wire [7:0] option_reg;
	wire [7:0] statusWord;
	wire [3:0] pinsClean;
	wire       errClean_n;
	wire       busyClean_n;
	wire       reqClean_n;
	wire       claimClean_n;

	// cpu ready decode takes the raw pin, unsynchronised, for the direct path, the one-flop synced path and the state machine
	wire readyPinRaw = ~coprocReadyIn_n;

	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	reg        present_reg;
	reg        busyLatch_reg;
	reg        strap386_reg;
	reg        strapReady_reg;
	reg [7:0]  rstCount_reg;
	reg        coprocCycle_reg;
	reg        readySync_reg;
	reg        errPrev_reg;
	reg        suspendPrev_reg;
	reg [7:0]  hardCount_reg;
	reg [7:0]  softDelay_reg;
	reg [7:0]  softCount_reg;

	clcp_axil_regs uRegs (
		.clk              (clk),
		.reset            (reset),
		.awaddr           (awaddr),
		.awvalid          (awvalid),
		.awready          (awready),
		.wdata            (wdata),
		.wstrb            (wstrb),
		.wvalid           (wvalid),
		.wready           (wready),
		.bresp            (bresp),
		.bvalid           (bvalid),
		.bready           (bready),
		.araddr           (araddr),
		.arvalid          (arvalid),
		.arready          (arready),
		.rdata            (rdata),
		.rresp            (rresp),
		.rvalid           (rvalid),
		.rready           (rready),
		.statusIn         (statusWord),
		.featureOne_reg   (featureOne_reg),
		.featureThree_reg (featureThree_reg),
		.option_reg       (option_reg)
	);

	clcp_sync3 #(
		.W    (4),
		.INIT (1'b1)
	) uSync (
		.clk   (clk),
		.reset (reset),
		.async ({fpErrorIn_n, fpBusyIn_n, localMasterRequestIn_n, localDeviceClaim_n}),
		.clean (pinsClean)
	);
	assign errClean_n   = pinsClean[3];
	assign busyClean_n  = pinsClean[2];
	assign reqClean_n   = pinsClean[1];
	assign claimClean_n = pinsClean[0];

	wire masterEn    = featureOne_reg[`CLCP_F1_MASTER_EN];
	wire readyDirect = featureThree_reg[`CLCP_F3_READY_DIRECT];
	wire detectOff   = featureThree_reg[`CLCP_F3_DETECT_OFF];
	wire pin80Dack   = featureThree_reg[`CLCP_F3_PIN80_DACK];
	wire softResetEn = featureThree_reg[`CLCP_F3_SOFT_RESET];
	wire a20mForce   = featureThree_reg[`CLCP_F3_ADDR20_MASK_FORCE];
	wire cpuZeroVolt = featureThree_reg[`CLCP_F3_CPU_ZERO_V];
	wire ignoreClaim = featureThree_reg[`CLCP_F3_IGNORE_CLAIM];
	wire wbCache     = option_reg[`CLCP_OPT_WB_CACHE];

	wire coprocOn    = present_reg && !detectOff && strap386_reg;
	wire readyPinOn  = strapReady_reg;
	wire fpPortWrite = cycleStart && cycleIsIo && cycleIsWrite && (cycleIoAddr == `CLCP_FP_PORT);
	wire errEvent    = errPrev_reg && !errClean_n;
	wire resumeEdge  = suspendPrev_reg && !suspendActive;

	assign statusWord = {3'b000, strapReady_reg, strap386_reg, irq13, busyLatch_reg, present_reg};

	// straps and presence are captured during the power-on reset pulse, after release
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rstCount_reg   <= 8'h00;
			fpResetOut     <= 1'b1;
			present_reg    <= 1'b0;
			strap386_reg   <= 1'b0;
			strapReady_reg <= 1'b0;
		end else begin
			if (rstCount_reg != RESET_CYCLES[7:0]) begin
				rstCount_reg   <= rstCount_reg + 8'h01;
				strap386_reg   <= strap386;
				strapReady_reg <= strapReadyPin;
				if (!errClean_n)
					present_reg <= 1'b1;
			end else begin
				fpResetOut <= 1'b0;
			end
		end
	end

	// set wins over the port write clear
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			busyLatch_reg <= 1'b0;
			irq13         <= 1'b0;
			errPrev_reg   <= 1'b1;
		end else begin
			errPrev_reg <= errClean_n;
			if (strap386_reg && errEvent && !busyClean_n) begin
				busyLatch_reg <= 1'b1;
				irq13         <= 1'b1;
			end else if (fpPortWrite) begin
				busyLatch_reg <= 1'b0;
				irq13         <= 1'b0;
			end
		end
	end

	// cycle ownership: local claim, own coprocessor claim, or isa with split count
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cycleStart && !cycleInDram) begin
					if (cpuAddrTopBit && coprocOn)
						state_next = ST_LOCAL;
					else if (!claimClean_n)
						state_next = ST_LOCAL;
					else
						state_next = ST_ISA;
				end
			end
			ST_LOCAL: begin
				if (readyPinRaw && readyPinOn)
					state_next = ST_END;
				else if (ignoreClaim && claimClean_n && !coprocCycle_reg)
					state_next = ST_ISA;
			end
			ST_ISA: begin
				if (isaCycleDone)
					state_next = ST_END;
			end
			ST_END: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg       <= ST_IDLE;
			coprocCycle_reg <= 1'b0;
			readySync_reg   <= 1'b0;
			cpuReady_n      <= 1'b1;
			cpuReadyOe      <= 1'b0;
			isaCycleReq     <= 1'b0;
			isaPieceCount   <= 3'd1;
		end else begin
			state_reg     <= state_next;
			readySync_reg <= readyPinOn && readyPinRaw && state_reg == ST_LOCAL;
			if (state_reg == ST_IDLE && cycleStart)
				coprocCycle_reg <= cpuAddrTopBit && coprocOn;
			isaCycleReq <= (state_next == ST_ISA);
			if (state_next == ST_ISA && state_reg != ST_ISA) begin
				if (cycleCpuSize > cycleDevSize)
					isaPieceCount <= 3'd1 << (cycleCpuSize - cycleDevSize);
				else
					isaPieceCount <= 3'd1;
			end
			// direct mode answers on the clock after the pin falls; synced mode one clock later
			if (state_reg == ST_LOCAL && readyPinOn && readyDirect && readyPinRaw) begin
				cpuReady_n <= 1'b0;
				cpuReadyOe <= 1'b1;
			end else if (readySync_reg && !readyDirect) begin
				cpuReady_n <= 1'b0;
				cpuReadyOe <= 1'b1;
			end else if (state_reg == ST_ISA && isaCycleDone) begin
				cpuReady_n <= 1'b0;
				cpuReadyOe <= 1'b1;
			end else begin
				cpuReady_n <= 1'b1;
				cpuReadyOe <= 1'b0;
			end
		end
	end

	// pin muxing and address-20 selection
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			localMasterGrant       <= 1'b0;
			pin80Out               <= 1'b1;
			progIoZeroOut          <= 1'b0;
			localMasterReq         <= 1'b0;
			encodedAckLines        <= 3'b111;
			swapBufferEnableHigh_n <= 1'b1;
			swapBufferEnableLow_n  <= 1'b1;
			swapBufferDirection    <= 1'b0;
			addr20Pin              <= 1'b0;
		end else begin
			localMasterReq   <= masterEn && !reqClean_n;
			localMasterGrant <= masterEn && localMasterReq;
			progIoZeroOut    <= masterEn ? 1'b0 : progIoZeroIn;
			if (masterEn)
				pin80Out <= ~localMasterReq;
			else if (strap386_reg && !pin80Dack)
				pin80Out <= fpIntInt | irq13;
			else
				pin80Out <= dmaAckCh2Int_n;
			encodedAckLines <= encodedAckInt;
			if (wbCache && state_reg == ST_ISA) begin
				swapBufferEnableHigh_n <= ~(cycleCpuSize != 2'd0);
				swapBufferEnableLow_n  <= 1'b0;
				swapBufferDirection    <= ~cycleIsWrite;
			end else begin
				swapBufferEnableHigh_n <= 1'b1;
				swapBufferEnableLow_n  <= 1'b1;
				swapBufferDirection    <= 1'b0;
			end
			addr20Pin <= (strap386_reg && !a20mForce) ? gateAddr20Int : ~gateAddr20Int;
		end
	end

	// resume resets
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			suspendPrev_reg <= 1'b0;
			hardCount_reg   <= 8'h00;
			softDelay_reg   <= 8'h00;
			softCount_reg   <= 8'h00;
			cpuHardReset    <= 1'b1;
			cpuSoftReset    <= 1'b0;
		end else begin
			suspendPrev_reg <= suspendActive;
			if (rstCount_reg != RESET_CYCLES[7:0])
				cpuHardReset <= 1'b1;
			else if (resumeEdge && cpuZeroVolt) begin
				hardCount_reg <= RESET_CYCLES[7:0];
				cpuHardReset  <= 1'b1;
			end else if (hardCount_reg != 8'h00) begin
				hardCount_reg <= hardCount_reg - 8'h01;
				cpuHardReset  <= 1'b1;
			end else
				cpuHardReset <= 1'b0;
			if (resumeEdge && softResetEn)
				softDelay_reg <= PWR_DELAY[7:0];
			else if (softDelay_reg != 8'h00) begin
				softDelay_reg <= softDelay_reg - 8'h01;
				if (softDelay_reg == 8'h01)
					softCount_reg <= RESET_CYCLES[7:0];
			end else if (softCount_reg != 8'h00)
				softCount_reg <= softCount_reg - 8'h01;
			cpuSoftReset <= (softCount_reg != 8'h00);
		end
	end
endmodule // clcp_coproc_support
`default_nettype wire

// ===== clcp_coproc_support_properties.sv
/* concurrent checks on the coprocessor support block ports: boot reset hold, cpu ready timing, irq13 latch.
   assumes a single clk domain with async active-high reset; bound into clcp_coproc_support by the bind below. */
`timescale 1ns/1ps
`default_nettype none
module clcp_coproc_support_properties #(
	parameter RESET_CYCLES = 128
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        cycleStart,
	input wire logic        cycleIsIo,
	input wire logic        cycleIsWrite,
	input wire logic [15:0] cycleIoAddr,
	input wire logic        strap386,
	input wire logic        isaCycleDone,
	input wire logic        coprocReadyIn_n,
	input wire logic [2:0]  encodedAckInt,
	input wire logic        cpuReady_n,
	input wire logic        cpuReadyOe,
	input wire logic        isaCycleReq,
	input wire logic        fpResetOut,
	input wire logic        cpuHardReset,
	input wire logic        irq13,
	input wire logic [2:0]  encodedAckLines
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	int  bootCnt;
	wire logic clrWr;
	assign clrWr = cycleStart && cycleIsIo && cycleIsWrite && cycleIoAddr == 16'h00f0;
	// saturates so a long run never wraps back into the boot window
	always @(posedge clk or posedge reset)
		if (reset) bootCnt <= 0;
		else if (bootCnt < 1000) bootCnt <= bootCnt + 1;

	a_boot_hold: assert property (bootCnt < RESET_CYCLES - 1 |-> fpResetOut && cpuHardReset)
		else $error("boot reset outputs released early");
	a_boot_release: assert property (bootCnt > RESET_CYCLES + 1 |-> !fpResetOut)
		else $error("coprocessor reset held too long");
	a_ready_pulse: assert property (!cpuReady_n |=> cpuReady_n)
		else $error("cpu ready low for more than one cycle");
	a_ready_drive: assert property (!cpuReady_n |-> cpuReadyOe)
		else $error("cpu ready low while not driven");
	a_ready_cause: assert property ($fell(cpuReady_n) |->
		!$past(coprocReadyIn_n) || !$past(coprocReadyIn_n, 2) || $past(isaCycleDone))
		else $error("cpu ready without a source");
	a_isa_ready: assert property (isaCycleReq && isaCycleDone |=> !cpuReady_n)
		else $error("no cpu ready after isa cycle end");
	a_ack_lines: assert property (!$past(reset) |-> encodedAckLines == $past(encodedAckInt))
		else $error("encoded ack lines lost");
	a_irq_hold: assert property (irq13 && !clrWr |=> irq13)
		else $error("irq13 dropped without clearing write");
	a_irq_clear: assert property (clrWr |=> !irq13)
		else $error("irq13 not cleared by port write");
	a_irq_strap: assert property ($rose(irq13) |-> strap386)
		else $error("irq13 raised outside 386 mode");

	cover property ($rose(irq13));
	cover property ($rose(isaCycleReq));
	cover property ($fell(cpuReady_n));
endmodule // clcp_coproc_support_properties

bind clcp_coproc_support clcp_coproc_support_properties #(.RESET_CYCLES(RESET_CYCLES)) clcp_props_inst (
	.clk, .reset, .cycleStart, .cycleIsIo, .cycleIsWrite, .cycleIoAddr, .strap386, .isaCycleDone,
	.coprocReadyIn_n, .encodedAckInt, .cpuReady_n, .cpuReadyOe, .isaCycleReq, .fpResetOut, .cpuHardReset,
	.irq13, .encodedAckLines);
`default_nettype wire

// ===== clcp_fpu_model.sv
/* behavioural numeric coprocessor on the cpu local bus: busy, raw ready pulse, presence and error.
   assumes go pulses for one clock with each coprocessor cycle; fault and busyReq come from the bench. */
`timescale 1ns/1ps
`default_nettype none
module clcp_fpu_model #(
	parameter PRESENT = 1
) (
	input  wire logic       clk,
	input  wire logic       fpResetOut,
	input  wire logic       go,
	input  wire logic [3:0] lat,
	input  wire logic       busyReq,
	input  wire logic       fault,
	output var  logic       coprocReadyIn_n,
	output var  logic       fpErrorIn_n,
	output var  logic       fpBusyIn_n
);
	logic [3:0] cnt;
	initial begin
		cnt = 4'h0;
		coprocReadyIn_n = 1'b1;
	end
	// ready is pulled up outside its one-cycle pulse
	always @(posedge clk) begin
		coprocReadyIn_n <= 1'b1;
		if (go) cnt <= lat;
		else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h1) coprocReadyIn_n <= 1'b0;
		end
	end
	always_comb fpBusyIn_n = !(cnt != 4'h0 || busyReq);
	always_comb fpErrorIn_n = fpResetOut ? !PRESENT : !fault;
endmodule // clcp_fpu_model
`default_nettype wire

// ===== clcp_coproc_support_tb.sv
/* self-checking bench for the coprocessor support block: registers, pins, ready timing, routing, irq13.
   assumes the fpu model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "clcp_map.vh"
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin mismatches++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module clcp_coproc_support_tb;
	localparam int RC = 8;
	logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic cycleStart = 0, cycleIsIo = 0, cycleIsWrite = 0, cpuAddrTopBit = 0, isaCycleDone = 0;
	logic localDeviceClaim_n = 1, localMasterRequestIn_n = 1, progIoZeroIn = 0, dmaAckCh2Int_n = 1;
	logic fpIntInt = 0, gateAddr20Int = 0, go = 0, busyReq = 0, fault = 0, suspendActive = 0;
	logic [9:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, seed = 32'd50429, rd, x;
	logic [3:0]  wstrb = 4'hf, lat = 4'h2;
	logic [1:0]  rr, cycleCpuSize = 0, cycleDevSize = 0;
	logic [15:0] cycleIoAddr = 0;
	logic [2:0]  encodedAckInt = 0;
	int          mismatches = 0, checkCount = 0, i, n, ra, ca;
	wire logic   awready, wready, bvalid, arready, rvalid, cpuReady_n, isaCycleReq, fpResetOut, irq13, addr20Pin;
	wire logic   coprocReadyIn_n, fpErrorIn_n, fpBusyIn_n;
	wire logic [1:0]  rresp;
	wire logic [31:0] rdata;
	wire logic [2:0]  encodedAckLines;
	wire logic   cpuHardReset, cpuSoftReset, pin80Out, progIoZeroOut, localMasterGrant, localMasterReq;
	wire logic   swapBufferEnableHigh_n, swapBufferEnableLow_n, swapBufferDirection;
	wire logic [2:0]  isaPieceCount;

	clcp_coproc_support #(.RESET_CYCLES(RC), .PWR_DELAY(4)) clcp_coproc_support_inst (
		.clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp(), .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .strap386(1'b1), .strapReadyPin(1'b1),
		.cycleStart, .cycleIsIo, .cycleIsWrite, .cycleInDram(1'b0), .cycleIoAddr, .cpuAddrTopBit, .cycleCpuSize,
		.cycleDevSize, .isaCycleDone, .coprocReadyIn_n, .localDeviceClaim_n, .fpErrorIn_n, .fpBusyIn_n,
		.localMasterRequestIn_n, .progIoZeroIn, .dmaAckCh2Int_n, .fpIntInt, .gateAddr20Int, .suspendActive,
		.encodedAckInt, .cpuReady_n, .cpuReadyOe(), .isaCycleReq, .isaPieceCount, .fpResetOut, .irq13,
		.localMasterGrant, .pin80Out, .progIoZeroOut, .localMasterReq, .encodedAckLines,
		.swapBufferEnableHigh_n, .swapBufferEnableLow_n, .swapBufferDirection, .addr20Pin,
		.cpuHardReset, .cpuSoftReset);
	clcp_fpu_model clcp_fpu_model_inst (.clk, .fpResetOut, .go, .lat, .busyReq, .fault, .coprocReadyIn_n,
		.fpErrorIn_n, .fpBusyIn_n);

	initial forever #12.5 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// a wide access to a narrow device takes twice as many pieces for each size step between cpu and device
	function automatic logic [2:0] pieces(input logic [1:0] c, input logic [1:0] d);
		return (c > d) ? 3'd1 << (c - d) : 3'd1;
	endfunction

	task automatic axW(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= {a, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axR(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= {a, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				d = rdata;
				r = rresp;
				break;
			end
		end
	endtask

	task automatic cyc(input logic io, input logic wr, input logic top, input logic [15:0] ad);
		@(posedge clk);
		x = rnd();
		cycleStart <= 1'b1;
		cycleIsIo <= io;
		cycleIsWrite <= wr;
		cpuAddrTopBit <= top;
		cycleIoAddr <= ad;
		cycleCpuSize <= x[1] ? 2'd2 : {1'b0, x[0]};
		cycleDevSize <= {1'b0, x[2]};
		go <= top;
		@(posedge clk);
		cycleStart <= 1'b0;
		go <= 1'b0;
	endtask

	// the isa engine answers once the request is seen, or after 12 clocks without it
	task automatic finishIsa;
		for (n = 0; n < 12 && isaCycleReq !== 1'b1; n++) @(posedge clk);
		`CHK(isaCycleReq, 1'b1)
		isaCycleDone <= 1'b1;
		@(posedge clk);
		isaCycleDone <= 1'b0;
		#1;
		`CHK(cpuReady_n, 1'b0)
		`CHK(isaPieceCount, pieces(cycleCpuSize, cycleDevSize))
		`CHK(swapBufferEnableHigh_n, cycleCpuSize == 2'd0)
		`CHK({swapBufferEnableLow_n, swapBufferDirection}, {1'b0, ~cycleIsWrite})
	endtask

	task results;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#1000000;
		mismatches++;
		results();
	end

	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (n = 0; n < 40 && fpResetOut !== 1'b0; n++) @(posedge clk);
		axR(`CLCP_OFF_FEATURE_ONE, rd, rr);
		`CHK(rd, 32'h0)
		axR(`CLCP_OFF_FEATURE_THR, rd, rr);
		`CHK(rd, 32'h0)
		axR(8'h10, rd, rr);
		`CHK({rr, rd}, {`CLCP_RESP_SLVERR, 32'h0})
		$display("test register defaults done");
		for (i = 0; i < 6; i++) begin
			x = rnd();
			axW(`CLCP_OFF_FEATURE_ONE, {24'h0, x[7:6], i[0], x[4:0]});
			axR(`CLCP_OFF_FEATURE_ONE, rd, rr);
			`CHK(rd, {24'h0, x[7:6], i[0], x[4:0]})
			@(posedge clk);
			{encodedAckInt, gateAddr20Int, progIoZeroIn, dmaAckCh2Int_n, fpIntInt, localMasterRequestIn_n} <= x[15:8];
			repeat (8) @(posedge clk);
			#1;
			`CHK(encodedAckLines, x[15:13])
			`CHK(addr20Pin, x[12])
			`CHK(progIoZeroOut, i[0] ? 1'b0 : x[11])
			`CHK({localMasterReq, localMasterGrant}, {2{i[0] & ~x[8]}})
			`CHK(pin80Out, i[0] ? x[8] : x[9])
		end
		$display("test pin functions done");
		for (i = 0; i < 4; i++) begin
			axW(`CLCP_OFF_FEATURE_THR, {31'h0, i[0]});
			x = rnd();
			lat <= {2'b00, x[1:0]} + 4'h2;
			cyc(1'b0, 1'b0, 1'b1, 16'h0);
			ra = -1;
			ca = -1;
			for (n = 0; n < 20; n++) begin
				@(posedge clk);
				#1;
				if (coprocReadyIn_n === 1'b0 && ra < 0) ra = n;
				if (cpuReady_n === 1'b0 && ca < 0) ca = n;
			end
			`CHK(ca - ra, i[0] ? 1 : 2)
		end
		$display("test coprocessor ready done");
		axW(`CLCP_OFF_OPTION, 32'h1);
		axW(`CLCP_OFF_FEATURE_THR, 32'h2);
		axR(`CLCP_OFF_FEATURE_THR, rd, rr);
		`CHK(rd, 32'h2)
		cyc(1'b0, 1'b0, 1'b1, 16'h0);
		finishIsa();
		cyc(1'b1, 1'b0, 1'b0, 16'h0060);
		finishIsa();
		axW(`CLCP_OFF_FEATURE_THR, 32'h80);
		localDeviceClaim_n <= 1'b0;
		repeat (6) @(posedge clk);
		cyc(1'b0, 1'b1, 1'b0, 16'h0);
		repeat (8) @(posedge clk);
		#1;
		`CHK(isaCycleReq, 1'b0)
		@(posedge clk);
		localDeviceClaim_n <= 1'b1;
		finishIsa();
		$display("test cycle routing done");
		busyReq <= 1'b1;
		repeat (6) @(posedge clk);
		fault <= 1'b1;
		for (n = 0; n < 12 && irq13 !== 1'b1; n++) @(posedge clk);
		repeat (20) @(posedge clk);
		#1;
		`CHK(irq13, 1'b1)
		@(posedge clk);
		fault <= 1'b0;
		busyReq <= 1'b0;
		axR(`CLCP_OFF_STATUS, rd, rr);
		`CHK(rd, 32'h1f)
		cyc(1'b1, 1'b1, 1'b0, 16'h00f1);
		finishIsa();
		`CHK(irq13, 1'b1)
		cyc(1'b1, 1'b1, 1'b0, 16'h00f0);
		finishIsa();
		`CHK(irq13, 1'b0)
		axR(`CLCP_OFF_STATUS, rd, rr);
		`CHK(rd, 32'h19)
		$display("test irq13 latch done");
		axW(`CLCP_OFF_FEATURE_THR, 32'h28);
		suspendActive <= 1'b1;
		@(posedge clk);
		suspendActive <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK({cpuHardReset, cpuSoftReset}, 2'b10)
		repeat (5) @(posedge clk);
		#1;
		`CHK({cpuHardReset, cpuSoftReset}, 2'b11)
		repeat (12) @(posedge clk);
		#1;
		`CHK({cpuHardReset, cpuSoftReset}, 2'b00)
		$display("test resume resets done");
		results();
	end
endmodule // clcp_coproc_support_tb
`default_nettype wire
